// ==== rtl/adc_link_pkg.sv ====
// Shared constants for both ends of the ADC serial read-out link.
// Assumes a 100 MHz system clock on the host and on the device's user side.
package adc_link_pkg;
  // Frame layout.
  localparam int RESULT_BITS = 16;
  localparam int LEAD_ZEROS = 8;
  localparam int FRAME_BITS = LEAD_ZEROS + RESULT_BITS;
  localparam int ACQ_EDGES = 6;
  localparam int EDGE_CNT_W = 5;
  localparam logic [RESULT_BITS-1:0] RESULT_RESET = 16'h0000;
  // Timing.
  localparam int CLK_SYS_PERIOD_PS = 10000;
  localparam int SCLK_MAX_KHZ = 4800;
  localparam int CS_HIGH_MIN_NS = 50;
  localparam int SCLK_PERIOD_MIN_PS = (1000000000 + SCLK_MAX_KHZ - 1) / SCLK_MAX_KHZ;
  localparam int SCLK_PERIOD_CYC = (SCLK_PERIOD_MIN_PS + CLK_SYS_PERIOD_PS - 1) / CLK_SYS_PERIOD_PS;
  localparam int SCLK_HALF_CYC = (SCLK_PERIOD_CYC + 1) / 2;
  localparam int CS_HIGH_CYC = (CS_HIGH_MIN_NS * 1000 + CLK_SYS_PERIOD_PS - 1) / CLK_SYS_PERIOD_PS;
  localparam int TIMER_W = 8;
  // Buffering.
  localparam int FIFO_DEPTH = 32;
  // Number of flops on a pin that crosses into another clock domain.
  localparam int SYNC_STAGES = 3;
endpackage : adc_link_pkg

// ==== rtl/adc_link_if.sv ====
// Wires between the converter end and the host end of the serial link.
// Assumes the line floats low when the converter releases it.
`timescale 1ns/1ps
interface adc_link_if;
  logic cs_n;
  logic sclk;
  logic dout_drv;
  logic dout_oe;
  logic dout_line;

  // A released output is seen as low, as a pull-down would leave it.
  assign dout_line = dout_oe & dout_drv;

  modport device (
    input cs_n,
    input sclk,
    output dout_drv,
    output dout_oe
  );
  modport host (
    output cs_n,
    output sclk,
    input dout_line
  );
endinterface : adc_link_if

// ==== rtl/adc_device_end.sv ====
// Converter end of the serial result read-out link.
// Assumes the host drives select and serial clock; the serial clock stands still
// outside frames, so the link-side logic is reset by select high rather than by rst_n_in.
// Function
// - Select falling edge starts a new frame.
// - Host uses clock idle low, phase zero.
// - Output changes only on serial clock falls.
// - Host samples output on serial clock rises.
// - Eight zeros precede the 16-bit result, MSB first.
// - Host reads three bytes or one stream.
// - Bytes are zeros, bits 15..8, bits 7..0.
// - Host holds select low through 24th fall.
// - Trailing zeros follow the LSB while clocked.
// - Host keeps select high at least 50 ns.
// - Select high mid-conversion aborts that conversion.
// - Host keeps serial clock at most 4.8 MHz.
// - Select high means shutdown and released output.
// - Output drives low; conversion begins after sixth cycle.
// - MSB follows eighth fall; later clocks ignored.
`timescale 1ns/1ps
module adc_device_end
  import adc_link_pkg::*;
#(
  parameter int RES_W = RESULT_BITS
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [RES_W-1:0] code_in,
  output logic [RES_W-1:0] sample_hold_out,
  output logic frame_start_out,
  output logic conv_done_out,
  output logic conv_abort_out,
  output logic busy_out,
  adc_link_if.device link
);

  // Link-side state, clocked by the falling serial clock edge.
  logic [EDGE_CNT_W-1:0] edge_cnt_q;
  logic [EDGE_CNT_W-1:0] edge_cnt_d;
  logic [RES_W-1:0] shift_q;
  logic dout_q;
  logic req_q;
  logic done_q;
  logic [SYNC_STAGES-1:0] ack_sync_q;

  // System-side state.
  logic [RES_W-1:0] hold_q;
  logic ack_q;
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] lvl_q;
  logic [2:0] lvl_d;
  logic busy_q;
  logic start_q;
  logic done_p_q;
  logic abort_q;

  // Decoded link-side conditions.
  wire acq_edge = (edge_cnt_q == EDGE_CNT_W'(ACQ_EDGES - 1));
  wire data_edge = (edge_cnt_q >= EDGE_CNT_W'(LEAD_ZEROS - 1)) &&
                   (edge_cnt_q <= EDGE_CNT_W'(FRAME_BITS - 2));
  // The LSB leaves at the 23rd fall, so done is marked there. Select may rise
  // together with the 24th fall and would clear a mark made at that fall.
  wire lsb_edge = (edge_cnt_q == EDGE_CNT_W'(FRAME_BITS - 2));
  wire frame_full = (edge_cnt_q == EDGE_CNT_W'(FRAME_BITS));
  wire ack_agreed = ack_sync_q[SYNC_STAGES-1] & ack_sync_q[SYNC_STAGES-2];

  // Filtered level of a three-flop synchroniser: it moves only once the
  // second and third stages agree, so a single metastable sample is ignored.
  function automatic logic agree(input logic cur, input logic st2, input logic st3);
    agree = (st2 == st3) ? st3 : cur;
  endfunction : agree

  // Edge counter saturates after the frame, so extra clocks change nothing.
  assign edge_cnt_d = frame_full ? edge_cnt_q : edge_cnt_q + EDGE_CNT_W'(1);

  // Frame position. Select high clears it asynchronously, because the serial
  // clock may already have stopped when select rises.
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      edge_cnt_q <= '0;
    end else begin
      edge_cnt_q <= edge_cnt_d;
    end
  end

  // Conversion result register. The held sample is copied in at the sixth
  // fall, once the system side has confirmed it is stable; without that
  // confirmation the frame carries zeros instead of a torn word.
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      shift_q <= '0;
    end else if (acq_edge) begin
      shift_q <= ack_agreed ? hold_q : '0;
    end else if (data_edge) begin
      shift_q <= {shift_q[RES_W-2:0], 1'b0};
    end
  end

  // Serial output bit. Zeros before the MSB and after the LSB; the MSB
  // leaves on the eighth fall, the LSB on the 23rd.
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      dout_q <= 1'b0;
    end else begin
      dout_q <= data_edge ? shift_q[RES_W-1] : 1'b0;
    end
  end

  // Acquisition request and completion levels towards the system side.
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      req_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      req_q <= 1'b1;
      done_q <= done_q | lsb_edge;
    end
  end

  // Acknowledge from the system side, synchronised onto the serial clock.
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      ack_sync_q <= '0;
    end else begin
      ack_sync_q <= {ack_sync_q[SYNC_STAGES-2:0], ack_q};
    end
  end

  // The output is released at once when select rises; no serial clock edge
  // is available then, so the enable follows the select pin directly.
  assign link.dout_oe = ~link.cs_n;
  assign link.dout_drv = dout_q;

  // Three-flop synchronisers for select, request and done on the system clock.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      s1_q <= 3'h1;
      s2_q <= 3'h1;
      s3_q <= 3'h1;
    end else begin
      s1_q <= {done_q, req_q, link.cs_n};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Agreed levels: bit 0 select, bit 1 request, bit 2 done.
  assign lvl_d[0] = agree(lvl_q[0], s2_q[0], s3_q[0]);
  assign lvl_d[1] = agree(lvl_q[1], s2_q[1], s3_q[1]);
  assign lvl_d[2] = agree(lvl_q[2], s2_q[2], s3_q[2]);

  // Edges of the agreed levels.
  wire cs_fall = lvl_q[0] & ~lvl_d[0];
  wire cs_rise = ~lvl_q[0] & lvl_d[0];
  wire req_rise = ~lvl_q[1] & lvl_d[1];
  wire done_rise = ~lvl_q[2] & lvl_d[2];

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      lvl_q <= 3'h1;
    end else begin
      lvl_q <= lvl_d;
    end
  end

  // Sample and hold. The held word only changes on a new request, and the
  // acknowledge follows the request level, so the link side reads a word
  // that has stood still for at least the synchroniser delay.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      hold_q <= RESULT_RESET;
      ack_q <= 1'b0;
    end else begin
      if (req_rise) begin
        hold_q <= code_in;
      end
      ack_q <= lvl_d[1];
    end
  end

  // Frame status. A frame counts as finished once the LSB has left;
  // done and a select rise in the same cycle count as done, not abort.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      busy_q <= 1'b0;
      start_q <= 1'b0;
      done_p_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      start_q <= cs_fall;
      done_p_q <= done_rise & busy_q;
      abort_q <= cs_rise & busy_q & ~done_rise;
      if (cs_fall) begin
        busy_q <= 1'b1;
      end else if (done_rise || cs_rise) begin
        busy_q <= 1'b0;
      end
    end
  end

  assign sample_hold_out = hold_q;
  assign frame_start_out = start_q;
  assign conv_done_out = done_p_q;
  assign conv_abort_out = abort_q;
  assign busy_out = busy_q;

endmodule : adc_device_end

// ==== rtl/adc_host_end.sv ====
// Host end of the serial result read-out link, with its result FIFO.
// Assumes one system clock; the serial clock is divided from it and driven out.
`timescale 1ns/1ps
module adc_result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;

  wire push = in_valid_in & in_ready_out;
  wire pop = out_valid_out & out_ready_in;

  assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rd_q];

  // Storage write.
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  // Pointers and fill level.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= push ? AW'((wr_q + 1'b1) % DEPTH) : wr_q;
      rd_q <= pop ? AW'((rd_q + 1'b1) % DEPTH) : rd_q;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : adc_result_fifo

module adc_host_end
  import adc_link_pkg::*;
#(
  parameter int RES_W = RESULT_BITS,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic byte_gap_in,
  output logic [RES_W-1:0] result_data_out,
  output logic result_valid_out,
  input wire logic result_ready_in,
  output logic frame_err_out,
  output logic busy_out,
  adc_link_if.host link
);
  typedef enum logic [2:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_GAP, ST_CSW} host_state_t;

  host_state_t state_q;
  logic [TIMER_W-1:0] tmr_q;
  logic [EDGE_CNT_W-1:0] bit_q;
  logic [FRAME_BITS-1:0] rx_q;
  logic cs_q;
  logic sclk_q;
  logic push_q;
  logic err_q;
  logic busy_q;
  logic [SYNC_STAGES-1:0] din_sync_q;
  logic din_q;
  logic fifo_ready;

  wire tmr_done = (tmr_q == '0);
  wire last_bit = (bit_q == EDGE_CNT_W'(FRAME_BITS - 1));
  wire byte_end = (bit_q[2:0] == 3'h7);
  wire din_d = (din_sync_q[2] == din_sync_q[1]) ? din_sync_q[2] : din_q;

  // Serial data pin through three flops; the level moves once stages agree.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      din_sync_q <= '0;
      din_q <= 1'b0;
    end else begin
      din_sync_q <= {din_sync_q[SYNC_STAGES-2:0], link.dout_line};
      din_q <= din_d;
    end
  end

  // Frame sequencer. Clock idles low and data is taken at each rising edge;
  // the half period leaves room for the synchroniser delay after each fall.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
      tmr_q <= '0;
      bit_q <= '0;
      cs_q <= 1'b1;
      sclk_q <= 1'b0;
      push_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      push_q <= 1'b0;
      tmr_q <= tmr_done ? tmr_q : tmr_q - 1'b1;
      unique case (state_q)
        ST_IDLE: begin
          // A frame starts only with room in the FIFO, so its push never fails.
          if (run_in && fifo_ready) begin
            cs_q <= 1'b0;
            busy_q <= 1'b1;
            bit_q <= '0;
            tmr_q <= TIMER_W'(SCLK_HALF_CYC - 1);
            state_q <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (!run_in) begin
            cs_q <= 1'b1;
            tmr_q <= TIMER_W'(CS_HIGH_CYC - 1);
            state_q <= ST_CSW;
          end else if (tmr_done) begin
            sclk_q <= 1'b1;
            rx_q <= {rx_q[FRAME_BITS-2:0], din_q};
            tmr_q <= TIMER_W'(SCLK_HALF_CYC - 1);
            state_q <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (tmr_done) begin
            sclk_q <= 1'b0;
            bit_q <= bit_q + EDGE_CNT_W'(1);
            if (last_bit) begin
              cs_q <= 1'b1;
              push_q <= 1'b1;
              tmr_q <= TIMER_W'(CS_HIGH_CYC - 1);
              state_q <= ST_CSW;
            end else if (byte_gap_in && byte_end) begin
              tmr_q <= TIMER_W'(SCLK_PERIOD_CYC - 1);
              state_q <= ST_GAP;
            end else begin
              tmr_q <= TIMER_W'(SCLK_HALF_CYC - 1);
              state_q <= ST_LOW;
            end
          end
        end
        ST_GAP: begin
          if (tmr_done) begin
            tmr_q <= TIMER_W'(SCLK_HALF_CYC - 1);
            state_q <= ST_LOW;
          end
        end
        ST_CSW: begin
          if (tmr_done) begin
            busy_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Leading byte must read zero; anything else marks the frame bad.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      err_q <= 1'b0;
    end else begin
      err_q <= push_q && (rx_q[FRAME_BITS-1:RES_W] != '0);
    end
  end

  adc_result_fifo #(
    .WIDTH(RES_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(push_q),
    .in_ready_out(fifo_ready),
    .in_data_in(rx_q[RES_W-1:0]),
    .out_valid_out(result_valid_out),
    .out_ready_in(result_ready_in),
    .out_data_out(result_data_out)
  );

  assign link.cs_n = cs_q;
  assign link.sclk = sclk_q;
  assign frame_err_out = err_q;
  assign busy_out = busy_q;
endmodule : adc_host_end

// ==== test/adc_link_assertions.sv ====
// Checker for the serial wires between the converter end and the host end.
// Assumes it sees the link signals and the host's system clock and reset.
`timescale 1ns/1ps
module adc_link_assertions (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dout_drv,
  input wire logic dout_oe,
  input wire logic dout_line
);
  logic sclk_q;
  logic [5:0] falls_q;

  // Counts clock falls in a frame; select high clears it, as in the converter.
  always_ff @(posedge clk_sys_in) begin
    sclk_q <= sclk;
    if (cs_n) begin
      falls_q <= 6'h00;
    end else if (sclk_q && !sclk) begin
      falls_q <= falls_q + 6'h01;
    end
  end

  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  a_oe_tracks_select: assert property (dout_oe == !cs_n)
    else $error("output enable differs from select");
  a_change_on_fall: assert property (!cs_n && $past(!cs_n) && $changed(dout_drv) |-> $fell(sclk))
    else $error("data changed away from a clock fall");
  a_lead_zeros_low: assert property (!cs_n && sclk && falls_q < 6'h08 |-> !dout_line)
    else $error("leading bit not zero");
  a_idle_clock_low: assert property (cs_n |-> !sclk)
    else $error("clock not low while deselected");
  a_select_gap_min: assert property ($rose(cs_n) |-> cs_n[*5])
    else $error("select high too briefly");
  a_frame_fall_count: assert property ($rose(cs_n) && $fell(sclk) |-> falls_q == 6'h17)
    else $error("frame ended at wrong fall");
  a_clock_high_time: assert property ($rose(sclk) |-> sclk[*8] ##1 sclk[*3])
    else $error("clock high phase too short");
  a_select_fall_drive: assert property ($fell(cs_n) |-> !sclk && dout_oe && !dout_line)
    else $error("line not driven low at frame start");
endmodule : adc_link_assertions

// ==== test/testbench.sv ====
// Self-checking bench: both link ends face each other through the interface.
// Assumes the package constants; a queue model predicts every result.
`timescale 1ns/1ps
module testbench;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic run_in = 1'b0;
  logic byte_gap_in = 1'b0;
  logic result_ready_in = 1'b0;
  logic [15:0] code_in = 16'h0000;
  logic [15:0] sample_hold_out, result_data_out, nxt;
  logic frame_start_out, conv_done_out, conv_abort_out, result_valid_out, frame_err_out, host_busy;
  logic dev_busy;
  logic [15:0] exp_q[$];
  logic [15:0] exp_last = 16'h0000;
  logic [23:0] wire_q = 24'h000000;
  int mismatches = 0;
  int total_checks = 0;
  int seed = 14231;
  int cycles = 0;
  int starts = 0;
  int pops = 0;
  int aborts = 0;
  int nbits = 0;
  int base = 0;

  adc_link_if adc_link_if_inst ();
  adc_device_end adc_device_end_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .code_in(code_in), .sample_hold_out(sample_hold_out), .frame_start_out(frame_start_out),
    .conv_done_out(conv_done_out), .conv_abort_out(conv_abort_out), .busy_out(dev_busy),
    .link(adc_link_if_inst));
  adc_host_end adc_host_end_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .run_in(run_in),
    .byte_gap_in(byte_gap_in), .result_data_out(result_data_out),
    .result_valid_out(result_valid_out), .result_ready_in(result_ready_in),
    .frame_err_out(frame_err_out), .busy_out(host_busy), .link(adc_link_if_inst));
  adc_link_assertions adc_link_assertions_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .cs_n(adc_link_if_inst.cs_n), .sclk(adc_link_if_inst.sclk),
    .dout_drv(adc_link_if_inst.dout_drv), .dout_oe(adc_link_if_inst.dout_oe),
    .dout_line(adc_link_if_inst.dout_line));

  // The system clock, 10 ns period.
  always #5 clk_sys_in = ~clk_sys_in;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : tick

  // Bounded wait; the cycle ceiling below also catches a hang.
  task automatic wait_cnt(ref int v, input int n);
    for (int i = 0; i < 4000 && v < n; i++) begin
      tick(1);
    end
  endtask : wait_cnt

  // Model: each frame start fixes a new random code; results return in that order.
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles > 40000) begin
      mismatches++;
      end_of_test();
    end
    if (rst_n_in) begin
      if (frame_start_out === 1'b1) begin
        check(32'(dev_busy), 32'h1);
        nxt = 16'($random(seed));
        code_in <= #1 nxt;
        exp_q.push_back(nxt);
        exp_last = nxt;
        starts++;
      end
      if (conv_done_out === 1'b1) check(32'(sample_hold_out), 32'(exp_last));
      if (conv_abort_out === 1'b1) begin
        aborts++;
        void'(exp_q.pop_back());
      end
      if (result_valid_out === 1'b1 && result_ready_in === 1'b1) begin
        pops++;
        check(32'(result_data_out), 32'(exp_q.pop_front()));
      end
      if (frame_err_out !== 1'b0) check(32'(frame_err_out), 32'h0);
    end
  end

  // Host view of the wire: one bit taken at each rise while selected.
  always @(posedge adc_link_if_inst.sclk) begin
    if (adc_link_if_inst.cs_n === 1'b0) begin
      wire_q = {wire_q[22:0], adc_link_if_inst.dout_line};
      nbits++;
    end
  end

  // A whole frame is eight zeros, then the code MSB first; partial frames are skipped.
  always @(posedge adc_link_if_inst.cs_n) begin
    if (nbits == 24) check(32'(wire_q), {16'h0000, exp_last});
    nbits = 0;
  end

  // Main sequence: streaming, abort, then fill and drain of the result buffer.
  initial begin
    tick(20);
    rst_n_in = 1'b1;
    run_in = 1'b1;
    result_ready_in = 1'b1;
    for (int i = 1; i <= 6; i++) begin
      byte_gap_in = i[0];
      wait_cnt(pops, i);
    end
    check(32'(pops), 32'd6);
    $display("test stream done");
    byte_gap_in = 1'b0;
    wait_cnt(starts, starts + 1);
    tick(20 + ($unsigned($random(seed)) % 300));
    run_in = 1'b0;
    wait_cnt(aborts, 1);
    check(32'(aborts), 32'd1);
    tick(20);
    run_in = 1'b1;
    wait_cnt(pops, 7);
    check(32'(pops), 32'd7);
    $display("test abort done");
    result_ready_in = 1'b0;
    base = starts;
    tick(18500);
    check(32'(starts - base), 32'd32);
    check(32'(result_valid_out), 32'h1);
    run_in = 1'b0;
    base = pops;
    for (int i = 0; i < 400 && pops < base + 32; i++) begin
      result_ready_in = 1'($random(seed));
      tick(1);
    end
    result_ready_in = 1'b1;
    tick(2);
    check(32'(pops - base), 32'd32);
    check(32'(result_valid_out), 32'h0);
    check(32'(host_busy), 32'h0);
    check(32'(dev_busy), 32'h0);
    $display("test buffer done");
    end_of_test();
  end
endmodule : testbench
